// [scs_consts.svh]
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// Timing
`define SCS_CLK_PERIOD_NS     8
`define SCS_STEP_TIME_NS      25000
`define SCS_HALF_STEP_CYCLES  ((`SCS_STEP_TIME_NS / 2) / `SCS_CLK_PERIOD_NS)
`define SCS_CARD_CLK_HALF     2

// Sequencer phases, in half step periods after t1 or t10
`define SCS_PH_SUPPLY_ON      5'd1
`define SCS_PH_IO_ENABLE      5'd8
`define SCS_PH_RST_ENABLE     5'd14
`define SCS_PH_CLK_STOP       5'd1
`define SCS_PH_IO_OFF         5'd2
`define SCS_PH_SUPPLY_OFF     5'd3
`define SCS_PH_GROUND         5'd10

// Card clock pulse counts
`define SCS_MASK_PULSES       8'd200
`define SCS_SAMPLE_PULSES     8'd31

// Output modes of the data contact
`define SCS_OUT_PULLUP        2'h0
`define SCS_OUT_PULL_LOW      2'h1
`define SCS_OUT_STRONG        2'h2

`endif

// [scs_pkg.sv]
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_IDLE       = 2'b00,
    SCS_ACTIVATE   = 2'b01,
    SCS_ACTIVE     = 2'b10,
    SCS_DEACTIVATE = 2'b11
  } scs_state_t;
endpackage

// [scs_sequencer.sv]
`timescale 1ns/1ps
`include "scs_consts.svh"
`default_nettype none

module scs_sequencer
  import scs_pkg::*;
#(
  parameter int HALF_STEP_CYCLES = `SCS_HALF_STEP_CYCLES,
  parameter int CARD_CLK_HALF    = `SCS_CARD_CLK_HALF,
  parameter int AUX_PORTS        = 6
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 session_start_n_in,
  input  wire logic                 host_reset_input_in,
  input  wire logic                 card_present_in,
  input  wire logic                 overcurrent_in,
  input  wire logic                 supply_short_in,
  input  wire logic                 io_in,
  input  wire logic                 io_tx_in,
  input  wire logic [1:0]           io_out_mode_in,
  input  wire logic                 io_data_in,
  input  wire logic [AUX_PORTS-1:0] aux_port_in,
  output logic                      converter_en_out,
  output logic                      low_imp_supply_disable_out,
  output logic                      card_supply_en_out,
  output logic                      card_clk_out,
  output logic                      card_rst_out,
  output logic                      rst_buffer_enable_out,
  output logic                      data_buffer_enable_out,
  output logic                      io_out,
  output logic                      io_oe_out,
  output logic                      io_pullup_out,
  output logic                      io_sample_out,
  output logic                      io_sample_strobe_out,
  output logic                      start_bit_out,
  output logic                      fault_irq_n_out,
  output logic                      session_active_out,
  output logic [AUX_PORTS-1:0]      aux_port_out
);

  // Two-flop synchronisers for pins
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic       start_n_s;
  logic       host_rst_s;
  logic       present_s;
  logic       ovc_s;
  logic       short_s;
  logic       io_s;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 6'h3f;
      sync2_reg <= 6'h3f;
    end else begin
      sync1_reg <= {session_start_n_in, host_reset_input_in, card_present_in,
                    ~overcurrent_in, ~supply_short_in, io_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign start_n_s  = sync2_reg[5];
  assign host_rst_s = sync2_reg[4];
  assign present_s  = sync2_reg[3];
  assign ovc_s      = ~sync2_reg[2];
  assign short_s    = ~sync2_reg[1];
  assign io_s       = sync2_reg[0];

  scs_state_t                 state_reg, state_next;
  logic [15:0]                pre_reg, pre_next;
  logic [4:0]                 phase_reg, phase_next;
  logic [7:0]                 cdiv_reg, cdiv_next;
  logic                       cref_reg, cref_next;
  logic [7:0]                 pulse_reg, pulse_next;
  logic                       masked_reg, masked_next;
  logic                       last_io_reg, last_io_next;
  logic                       armed_reg, armed_next;
  logic                       removal_reg, removal_next;
  logic                       conv_reg, conv_next;
  logic                       lisd_reg, lisd_next;
  logic                       vcc_reg, vcc_next;
  logic                       cclk_reg, cclk_next;
  logic                       crst_reg, crst_next;
  logic                       rstbuf_reg, rstbuf_next;
  logic                       iobuf_reg, iobuf_next;
  logic                       ioo_reg, ioo_next;
  logic                       iooe_reg, iooe_next;
  logic                       pu_reg, pu_next;
  logic                       smp_reg, smp_next;
  logic                       stb_reg, stb_next;
  logic                       sbit_reg, sbit_next;
  logic                       irq_n_reg, irq_n_next;
  logic [AUX_PORTS-1:0]       aux_reg, aux_next;

  logic half_tick;
  logic cref_rise;
  logic clk_allow;
  logic fault_now;

  always_comb begin
    // Step tick: the clock divided by HALF_STEP_CYCLES becomes one half step here
    half_tick = (pre_reg == 16'(HALF_STEP_CYCLES - 1));
    pre_next  = half_tick ? 16'h0000 : pre_reg + 16'h0001;

    cdiv_next = (cdiv_reg == 8'(CARD_CLK_HALF - 1)) ? 8'h00 : cdiv_reg + 8'h01;
    cref_next = (cdiv_reg == 8'(CARD_CLK_HALF - 1)) ? ~cref_reg : cref_reg;
    cref_rise = (cdiv_reg == 8'(CARD_CLK_HALF - 1)) && !cref_reg;

    state_next   = state_reg;
    phase_next   = (half_tick && phase_reg != 5'h1f) ? phase_reg + 5'h01 : phase_reg;
    armed_next   = armed_reg | start_n_s;
    removal_next = removal_reg;
    irq_n_next   = irq_n_reg;

    fault_now = ovc_s || short_s ||
                (state_reg != SCS_IDLE && !present_s);

    unique case (state_reg)
      SCS_IDLE: begin
        phase_next = 5'h00;
        if (irq_n_reg == 1'b0 && (!removal_reg || present_s)) begin
          irq_n_next   = 1'b1;
          removal_next = 1'b0;
        end
        // Armed only after start seen high, so a held start cannot restart a faulted card
        if (!start_n_s && armed_reg && present_s && !ovc_s && !short_s && irq_n_reg) begin
          state_next = SCS_ACTIVATE;
          pre_next   = 16'h0000;
        end
      end
      SCS_ACTIVATE, SCS_ACTIVE: begin
        if (fault_now) begin
          irq_n_next   = 1'b0;
          removal_next = !present_s;
          armed_next   = 1'b0;
          state_next   = SCS_DEACTIVATE;
          phase_next   = 5'h00;
          pre_next     = 16'h0000;
        end else if (start_n_s) begin
          state_next = SCS_DEACTIVATE;
          phase_next = 5'h00;
          pre_next   = 16'h0000;
        end else if (state_reg == SCS_ACTIVATE && phase_next >= `SCS_PH_RST_ENABLE) begin
          // Move on the half step itself, so reset buffer lands exactly at 7T
          state_next = SCS_ACTIVE;
        end
      end
      SCS_DEACTIVATE: begin
        if (fault_now) begin
          irq_n_next = 1'b0;
          removal_next = removal_reg | !present_s;
        end
        if (phase_next >= `SCS_PH_GROUND) begin
          state_next = SCS_IDLE;
        end
      end
    endcase

    // Contact drive by state and phase
    conv_next   = (state_next != SCS_IDLE);
    lisd_next   = 1'b0;
    vcc_next    = 1'b0;
    iobuf_next  = 1'b0;
    rstbuf_next = 1'b0;
    clk_allow   = 1'b0;
    if (state_next == SCS_ACTIVATE || state_next == SCS_ACTIVE) begin
      lisd_next   = (phase_next >= `SCS_PH_SUPPLY_ON) || state_next == SCS_ACTIVE;
      vcc_next    = lisd_next;
      iobuf_next  = (phase_next >= `SCS_PH_IO_ENABLE) || state_next == SCS_ACTIVE;
      rstbuf_next = (state_next == SCS_ACTIVE);
      // Window t3..t5: host reset line meters the clock
      clk_allow   = (state_next == SCS_ACTIVE) || (iobuf_next && host_rst_s);
    end else if (state_next == SCS_DEACTIVATE) begin
      lisd_next  = 1'b1;
      vcc_next   = (phase_next < `SCS_PH_SUPPLY_OFF);
      iobuf_next = (phase_next < `SCS_PH_IO_OFF);
      clk_allow  = (phase_next < `SCS_PH_CLK_STOP);
    end
    cclk_next = cref_next && clk_allow;
    crst_next = rstbuf_next && !host_rst_s;

    // Data contact
    pulse_next   = pulse_reg;
    masked_next  = masked_reg;
    last_io_next = last_io_reg;
    smp_next     = smp_reg;
    stb_next     = 1'b0;
    sbit_next    = 1'b0;
    ioo_next     = 1'b0;
    iooe_next    = 1'b0;
    pu_next      = 1'b0;
    if (!iobuf_next) begin
      pulse_next   = 8'h00;
      masked_next  = 1'b1;
      last_io_next = 1'b1;
      smp_next     = 1'b1;
    end else if (io_tx_in) begin
      pulse_next = 8'h00;
      unique case (io_out_mode_in)
        `SCS_OUT_PULL_LOW: begin
          iooe_next = 1'b1;
          pu_next   = 1'b1;
        end
        `SCS_OUT_STRONG: begin
          iooe_next = 1'b1;
          ioo_next  = io_data_in;
        end
        default: begin
          pu_next = 1'b1;
        end
      endcase
    end else begin
      pu_next = 1'b1;
      if (cref_rise && cclk_next) begin
        if (masked_reg) begin
          pulse_next = pulse_reg + 8'h01;
          if (pulse_reg == `SCS_MASK_PULSES - 8'h01) begin
            masked_next = 1'b0;
            pulse_next  = 8'h00;
          end
        end else if (pulse_reg == `SCS_SAMPLE_PULSES - 8'h01) begin
          pulse_next   = 8'h00;
          stb_next     = 1'b1;
          smp_next     = io_s;
          last_io_next = io_s;
          sbit_next    = last_io_reg && !io_s;
        end else begin
          pulse_next = pulse_reg + 8'h01;
        end
      end
    end

    aux_next = aux_port_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg   <= SCS_IDLE;
      pre_reg     <= 16'h0000;
      phase_reg   <= 5'h00;
      cdiv_reg    <= 8'h00;
      cref_reg    <= 1'b0;
      pulse_reg   <= 8'h00;
      masked_reg  <= 1'b1;
      last_io_reg <= 1'b1;
      armed_reg   <= 1'b0;
      removal_reg <= 1'b0;
      conv_reg    <= 1'b0;
      lisd_reg    <= 1'b0;
      vcc_reg     <= 1'b0;
      cclk_reg    <= 1'b0;
      crst_reg    <= 1'b0;
      rstbuf_reg  <= 1'b0;
      iobuf_reg   <= 1'b0;
      ioo_reg     <= 1'b0;
      iooe_reg    <= 1'b0;
      pu_reg      <= 1'b0;
      smp_reg     <= 1'b1;
      stb_reg     <= 1'b0;
      sbit_reg    <= 1'b0;
      irq_n_reg   <= 1'b1;
      aux_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      pre_reg     <= pre_next;
      phase_reg   <= phase_next;
      cdiv_reg    <= cdiv_next;
      cref_reg    <= cref_next;
      pulse_reg   <= pulse_next;
      masked_reg  <= masked_next;
      last_io_reg <= last_io_next;
      armed_reg   <= armed_next;
      removal_reg <= removal_next;
      conv_reg    <= conv_next;
      lisd_reg    <= lisd_next;
      vcc_reg     <= vcc_next;
      cclk_reg    <= cclk_next;
      crst_reg    <= crst_next;
      rstbuf_reg  <= rstbuf_next;
      iobuf_reg   <= iobuf_next;
      ioo_reg     <= ioo_next;
      iooe_reg    <= iooe_next;
      pu_reg      <= pu_next;
      smp_reg     <= smp_next;
      stb_reg     <= stb_next;
      sbit_reg    <= sbit_next;
      irq_n_reg   <= irq_n_next;
      aux_reg     <= aux_next;
    end
  end

  assign converter_en_out           = conv_reg;
  assign low_imp_supply_disable_out = lisd_reg;
  assign card_supply_en_out         = vcc_reg;
  assign card_clk_out               = cclk_reg;
  assign card_rst_out               = crst_reg;
  assign rst_buffer_enable_out      = rstbuf_reg;
  assign data_buffer_enable_out     = iobuf_reg;
  assign io_out                     = ioo_reg;
  assign io_oe_out                  = iooe_reg;
  assign io_pullup_out              = pu_reg;
  assign io_sample_out              = smp_reg;
  assign io_sample_strobe_out       = stb_reg;
  assign start_bit_out              = sbit_reg;
  assign fault_irq_n_out            = irq_n_reg;
  // Converter runs exactly while not idle, so its flop doubles as the flag
  assign session_active_out         = conv_reg;
  assign aux_port_out               = aux_reg;

endmodule

`default_nettype wire

// [scs_sequencer_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_monitor #(
  parameter int HALF_STEP_CYCLES = 4,
  parameter int CARD_CLK_HALF    = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic host_reset_input_in,
  input wire logic overcurrent_in,
  input wire logic converter_en_out,
  input wire logic card_supply_en_out,
  input wire logic card_clk_out,
  input wire logic card_rst_out,
  input wire logic rst_buffer_enable_out,
  input wire logic data_buffer_enable_out,
  input wire logic io_oe_out,
  input wire logic io_pullup_out,
  input wire logic io_sample_strobe_out,
  input wire logic fault_irq_n_out,
  input wire logic session_active_out
);
  int unsigned wcnt_reg, dcnt_reg, gap_reg;
  logic [3:0]  hr_reg, rb_reg;
  logic        deact_reg, rb_fell;
  assign rb_fell = rb_reg[0] && !rst_buffer_enable_out;
  always_ff @(posedge clk_in) begin
    hr_reg    <= {hr_reg[2:0], host_reset_input_in};
    rb_reg    <= {rb_reg[2:0], rst_buffer_enable_out};
    wcnt_reg  <= data_buffer_enable_out ? wcnt_reg + 1 : 0;
    gap_reg   <= !data_buffer_enable_out ? 0 : io_sample_strobe_out ? 1 : gap_reg + 1;
    dcnt_reg  <= rb_fell ? 1 : dcnt_reg + 1;
    deact_reg <= session_active_out && (deact_reg || rb_fell);
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_idle_gnd;
    !session_active_out && !$past(session_active_out) |->
      !(converter_en_out | card_supply_en_out | card_clk_out | card_rst_out | data_buffer_enable_out);
  endproperty
  a_idle_gnd: assert property (p_idle_gnd)
    else $error("contact live while idle");
  property p_buf_off;
    !data_buffer_enable_out && !$past(data_buffer_enable_out) |-> !io_oe_out && !io_pullup_out;
  endproperty
  a_buf_off: assert property (p_buf_off)
    else $error("data buffer active while disabled");
  property p_conv_first;
    $rose(converter_en_out) |-> !card_supply_en_out && !data_buffer_enable_out;
  endproperty
  a_conv_first: assert property (p_conv_first)
    else $error("converter not first");
  property p_rst_time;
    $rose(rst_buffer_enable_out) |-> wcnt_reg == 6 * HALF_STEP_CYCLES;
  endproperty
  a_rst_time: assert property (p_rst_time)
    else $error("reset buffer enable mistimed");
  property p_deact_end;
    $fell(converter_en_out) && deact_reg |-> !card_supply_en_out &&
      dcnt_reg > 9 * HALF_STEP_CYCLES && dcnt_reg <= 10 * HALF_STEP_CYCLES;
  endproperty
  a_deact_end: assert property (p_deact_end)
    else $error("converter stop mistimed");
  property p_rst_follow;
    rst_buffer_enable_out && &rb_reg && hr_reg == {4{host_reset_input_in}} |->
      card_rst_out == !host_reset_input_in;
  endproperty
  a_rst_follow: assert property (p_rst_follow)
    else $error("card reset not inverse of host reset");
  property p_fault;
    $rose(overcurrent_in) && session_active_out && fault_irq_n_out |->
      ##[1:4] !fault_irq_n_out ##[0:2] !rst_buffer_enable_out;
  endproperty
  a_fault: assert property (p_fault)
    else $error("overcurrent not flagged");
  property p_gap;
    io_sample_strobe_out |-> gap_reg >= 62 * CARD_CLK_HALF && wcnt_reg >= 400 * CARD_CLK_HALF;
  endproperty
  a_gap: assert property (p_gap)
    else $error("data sample too early");
endmodule
bind scs_sequencer scs_sequencer_monitor #(
  .HALF_STEP_CYCLES(HALF_STEP_CYCLES),
  .CARD_CLK_HALF(CARD_CLK_HALF)
) u_mon (.*);
`default_nettype wire

// [scs_card_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_card_model #(
  parameter int ANSWER_PULSES = 250
) (
  input  wire logic supply_in,
  input  wire logic card_clk_in,
  input  wire logic card_rst_in,
  input  wire logic io_drive_in,
  input  wire logic io_oe_in,
  input  wire logic io_pullup_in,
  output logic      io_line_out
);
  int unsigned pulses = 0;
  logic        answer;
  always @(posedge card_clk_in) begin
    if (!card_rst_in) pulses <= 0;
    else pulses <= pulses + 1;
  end
  // Start bit longer than one sample spacing
  assign answer = supply_in && card_rst_in && pulses >= ANSWER_PULSES && pulses < ANSWER_PULSES + 40;
  // Released and not pulled up, the contact sits at ground
  assign io_line_out = io_oe_in ? io_drive_in : answer ? 1'b0 : io_pullup_in;
endmodule
`default_nettype wire

// [scs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
`define WAIT(c) for (int w = 0; w < 3000 && !(c); w++) cyc(1);
module scs_sequencer_tb;
  logic       clk_in, rst_n_in, session_start_n_in, host_reset_input_in, card_present_in;
  logic       overcurrent_in, supply_short_in, io_in, io_tx_in, io_data_in, seen;
  logic       converter_en_out, low_imp_supply_disable_out, card_supply_en_out, card_clk_out;
  logic       card_rst_out, rst_buffer_enable_out, data_buffer_enable_out, io_out, io_oe_out;
  logic       io_pullup_out, io_sample_out, io_sample_strobe_out, start_bit_out;
  logic       fault_irq_n_out, session_active_out;
  logic [1:0] io_out_mode_in;
  logic [5:0] aux_port_in, aux_port_out;
  int         checks = 0;
  int         n_mismatch = 0;
  int         t;
  scs_sequencer #(.HALF_STEP_CYCLES(4), .CARD_CLK_HALF(2)) dut (.*);
  scs_card_model card (.supply_in(card_supply_en_out), .card_clk_in(card_clk_out), .card_rst_in(card_rst_out),
    .io_drive_in(io_out), .io_oe_in(io_oe_out), .io_pullup_in(io_pullup_out), .io_line_out(io_in));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic clk_runs(input logic exp);
    seen = 0;
    repeat (8) begin
      cyc(1);
      seen |= card_clk_out;
    end
    `CHK("card_clk", exp, seen)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {rst_n_in, host_reset_input_in, overcurrent_in, supply_short_in, io_tx_in, io_data_in} = '0;
    {session_start_n_in, card_present_in} = '1;
    io_out_mode_in = 2'h0;
    aux_port_in = 6'h00;
    cyc(16);
    rst_n_in = 1;
    cyc(2);
    `CHK("lisd", 1'b0, low_imp_supply_disable_out)
    session_start_n_in = 0;
    `WAIT(converter_en_out)
    `CHK("vcc", 1'b0, card_supply_en_out)
    for (t = 0; !data_buffer_enable_out && t < 100; t++) cyc(1);
    `CHK("t3", 1'b1, t inside {[31:32]})
    `CHK("lisd", 1'b1, low_imp_supply_disable_out)
    clk_runs(1'b0);
    host_reset_input_in = 1;
    clk_runs(1'b1);
    `WAIT(rst_buffer_enable_out)
    host_reset_input_in = 0;
    cyc(4);
    `CHK("card_rst", 1'b1, card_rst_out)
    clk_runs(1'b1);
    `WAIT(start_bit_out)
    `CHK("start", 1'b1, start_bit_out)
    `CHK("sample", 1'b0, io_sample_out)
    $display("test activation finished");
    io_tx_in = 1;
    for (int m = 0; m < 3; m++) begin
      io_out_mode_in = m[1:0];
      io_data_in = 1;
      cyc(2);
      `CHK("oe", m != 0, io_oe_out)
      `CHK("pullup", m != 2, io_pullup_out)
      `CHK("drive", m == 2, io_out & io_oe_out)
    end
    io_tx_in = 0;
    aux_port_in = 6'h2a;
    cyc(2);
    `CHK("aux", 6'h2a, aux_port_out)
    $display("test modes finished");
    session_start_n_in = 1;
    `WAIT(!rst_buffer_enable_out)
    `CHK("card_rst", 1'b0, card_rst_out)
    session_start_n_in = 0;
    `WAIT(!data_buffer_enable_out)
    `CHK("vcc", 1'b1, card_supply_en_out)
    `CHK("card_clk", 1'b0, card_clk_out)
    `WAIT(!converter_en_out)
    `CHK("lisd", 1'b0, low_imp_supply_disable_out)
    `WAIT(converter_en_out)
    `CHK("restart", 1'b1, converter_en_out)
    $display("test deactivation finished");
    `WAIT(rst_buffer_enable_out)
    overcurrent_in = 1;
    cyc(5);
    `CHK("irq", 1'b0, fault_irq_n_out)
    overcurrent_in = 0;
    `WAIT(!session_active_out)
    cyc(2);
    `CHK("irq", 1'b1, fault_irq_n_out)
    session_start_n_in = 1;
    cyc(4);
    session_start_n_in = 0;
    `WAIT(rst_buffer_enable_out)
    supply_short_in = 1;
    cyc(5);
    `CHK("irq_short", 1'b0, fault_irq_n_out)
    supply_short_in = 0;
    `WAIT(!session_active_out)
    cyc(2);
    `CHK("irq_short", 1'b1, fault_irq_n_out)
    session_start_n_in = 1;
    cyc(4);
    session_start_n_in = 0;
    `WAIT(rst_buffer_enable_out)
    card_present_in = 0;
    `WAIT(!session_active_out)
    cyc(4);
    `CHK("irq", 1'b0, fault_irq_n_out)
    card_present_in = 1;
    cyc(6);
    `CHK("irq", 1'b1, fault_irq_n_out)
    $display("test faults finished");
    wrap_up();
  end
endmodule
`default_nettype wire
